// file: pibw_pkg.sv
/*
  package for the endpoint inbound boot-window block: register offsets,
  strap values, field positions and fixed addresses.
  assumes a 32-bit register port with word-aligned offsets.
*/
package pibw_pkg;
  // ==========================================================
  // register offsets (byte addresses on the register port)
  localparam logic [31:0] OFF_BAR_ZERO_BASE = 32'h0000_0010;
  localparam logic [31:0] OFF_BAR_ONE_BASE = 32'h0000_0014;
  localparam logic [31:0] OFF_WINDOW_INDEX_SELECT = 32'h0000_0900;
  localparam logic [31:0] OFF_WINDOW_REGION_CONTROL_TWO = 32'h0000_0908;
  localparam logic [31:0] OFF_WINDOW_TARGET_LOWER = 32'h0000_0918;
  localparam logic [31:0] OFF_WINDOW_TARGET_UPPER = 32'h0000_091c;
  localparam logic [31:0] OFF_BAR_ZERO_SIZE_MASK = 32'h0000_1010;
  localparam logic [31:0] OFF_BAR_ONE_SIZE_MASK = 32'h0000_1014;
  localparam logic [31:0] OFF_BOOT_SCRATCH_ONE = 32'h0157_0600;
  localparam logic [31:0] OFF_BOOT_JUMP_SCRATCH = 32'h0157_0604;
  // ==========================================================
  // power-on strap values
  localparam logic [2:0] HOST_AGENT_ENDPOINT = 3'h1;
  localparam logic [15:0] SERDES_PROTO_GROUP_ONE = 16'h1133;
  localparam logic [15:0] SERDES_PROTO_GROUP_TWO = 16'h5506;
  localparam logic [1:0] SERDES_DIV_MAX = 2'h0;
  // ==========================================================
  // index register: bit 31 selects inbound, bit 0 window number
  localparam int IDX_INBOUND_BIT = 31;
  // region control two: enable, bar match, bar number field
  localparam int RC2_ENABLE_BIT = 31;
  localparam int RC2_BAR_MATCH_BIT = 30;
  localparam int RC2_BAR_LSB = 8;
  // ==========================================================
  // reset values and boot addresses
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [31:0] RESET_JUMP_ADDR = 32'h1000_0000;
  localparam logic [31:0] MAILBOX_ADDR = 32'h1001_0000;
  localparam logic [31:0] DRAM_BOOT_ADDR = 32'h8200_0000;
  localparam logic [31:0] BAR_ZERO_MASK_RESET = 32'h1fff_ffff;
  localparam logic [31:0] BAR_ONE_MASK_RESET = 32'h1fff_ffff;
  // window destinations
  typedef enum logic [1:0] {
    PIBW_DEST_NONE,
    PIBW_DEST_REGS_RAM,
    PIBW_DEST_DRAM
  } pibw_dest_t;
endpackage

// file: pibw_win_if.sv
/*
  interface carrying one inbound window's settings from the register
  file to the address translator.
  assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
interface pibw_win_if;
  logic enable;
  logic bar_match;
  logic bar_sel;
  logic [31:0] bar_base;
  logic [31:0] bar_mask;
  logic [63:0] target;
  modport regs (output enable, bar_match, bar_sel, bar_base, bar_mask,
    target);
  modport xlat (input enable, bar_match, bar_sel, bar_base, bar_mask,
    target);
endinterface

// file: pibw_xlat.sv
/*
  inbound address translator for one window: bar match check and
  target plus offset address formation, registered output.
  assumes window settings are steady while requests flow.
*/
`timescale 1ns/1ps
module pibw_xlat (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // window settings
  pibw_win_if.xlat win,
  // inbound request
  input wire logic req_valid,
  input wire logic req_bar,
  input wire logic [31:0] req_addr,
  // result
  output logic hit_q,
  output logic [63:0] local_addr_q
);
  logic hit_d;
  logic [63:0] local_addr_d;
  logic [31:0] offset;

  // ==========================================================
  // match request bar against enabled window, add masked offset
  always_comb begin
    offset = req_addr & win.bar_mask;
    hit_d = req_valid && win.enable && win.bar_match &&
      (req_bar == win.bar_sel); // RULE7 RULE8
    local_addr_d = local_addr_q;
    if (hit_d) begin
      local_addr_d = win.target + {32'h0000_0000, offset}; // RULE15
    end
  end

  // ==========================================================
  // register result
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hit_q <= 1'b0;
      local_addr_q <= 64'h0;
    end else begin
      hit_q <= hit_d;
      local_addr_q <= local_addr_d;
    end
  end
endmodule

// file: pibw_top.sv
/*
  endpoint inbound boot windows: power-on straps, bar and window
  registers, boot scratch registers, mailbox boot release and two
  bar-matched inbound translation windows.
  assumes a simple synchronous register port (valid, write, address,
  data) answered in the next cycle, and inbound requests already
  decoded to a bar number by the link layer.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: a 3-bit strap selects endpoint operation when it reads 3'b001.
// RULE2: each serdes group lane width comes from its protocol strap.
// RULE3: each serdes group max link speed comes from a 2-bit strap.
// RULE4: processor jumps to the second scratch value, loaded 0x10000000.
// RULE5: first scratch register is written with zero during preboot.
// RULE6: after link training, registers and dram are exposed inbound.
// RULE7: window 0 matches bar_zero_base and routes to registers and ram from 0; the code matches req_bar to the rc2 bar field, never bar_base.
// RULE8: window 1 matches bar_one_base and routes to dram; the code matches req_bar to the rc2 bar field, never bar_base.
// RULE9: bar size masks sit at 0x1010 and 0x1014.
// RULE10: bar_zero_base at 0x10, bar_one_base at 0x14.
// RULE11: index register at 0x900 picks the window for region registers.
// RULE12: region control two at 0x908 enables window in bar match mode.
// RULE13: target address comes from 0x918 lower and 0x91c upper.
// RULE14: clear mailbox, wait non-zero, then run from dram 0x82000000.
// RULE15: local address is target plus masked offset within the bar.
module pibw_top #(
  parameter int NUM_WIN = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // power-on straps and link training status
  input wire logic [2:0] host_agent_select,
  input wire logic [15:0] serdes_protocol_field_one,
  input wire logic [15:0] serdes_protocol_field_two,
  input wire logic [1:0] serdes_speed_divider_one,
  input wire logic [1:0] serdes_speed_divider_two,
  input wire logic link_up,
  // register port
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ready,
  output logic [31:0] reg_rdata_q,
  output logic reg_error_q,
  // inbound request
  input wire logic req_valid,
  input wire logic req_bar,
  input wire logic [31:0] req_addr,
  output logic resp_hit_q,
  output logic [1:0] resp_dest_q,
  output logic [63:0] resp_local_addr_q,
  // straps decoded and boot state
  output logic endpoint_mode_q,
  output logic [15:0] lane_width_one_q,
  output logic [15:0] lane_width_two_q,
  output logic [1:0] link_speed_one_q,
  output logic [1:0] link_speed_two_q,
  output logic boot_released_q,
  output logic [31:0] boot_fetch_addr_q
);
  // refuse a window count the fixed two-way merge cannot serve
  if (NUM_WIN != 2) begin : g_bad_num_win
    $error("pibw_top serves exactly two inbound windows");
  end

  typedef enum logic [1:0] {
    PIBW_BOOT_CLEAR,
    PIBW_BOOT_WAIT,
    PIBW_BOOT_RUN
  } pibw_boot_t;

  logic strap_taken_q, strap_taken_d;
  logic endpoint_mode_d;
  logic [15:0] lane_width_one_d, lane_width_two_d;
  logic [1:0] link_speed_one_d, link_speed_two_d;
  logic [31:0] bar_base_q [NUM_WIN];
  logic [31:0] bar_base_d [NUM_WIN];
  logic [31:0] bar_mask_q [NUM_WIN];
  logic [31:0] bar_mask_d [NUM_WIN];
  logic [31:0] rc2_q [NUM_WIN];
  logic [31:0] rc2_d [NUM_WIN];
  logic [31:0] tgt_lo_q [NUM_WIN];
  logic [31:0] tgt_lo_d [NUM_WIN];
  logic [31:0] tgt_hi_q [NUM_WIN];
  logic [31:0] tgt_hi_d [NUM_WIN];
  logic [31:0] index_q, index_d;
  logic [31:0] scratch_one_q, scratch_one_d;
  logic [31:0] jump_q, jump_d;
  logic [31:0] mailbox_q, mailbox_d;
  logic [31:0] rdata_d;
  logic err_d;
  logic sel_win;
  logic sel_inbound;
  pibw_boot_t boot_q, boot_d;
  logic [31:0] fetch_d;
  logic [NUM_WIN-1:0] hit;
  logic [63:0] laddr [NUM_WIN];
  logic dest_valid_q, dest_valid_d;

  // true when the register address equals the given offset, with no window or inbound check
  function automatic logic is_addr(input logic [31:0] a,
                                   input logic [31:0] off);
    is_addr = (a == off);
  endfunction

  assign reg_ready = 1'b1;
  assign sel_win = index_q[0]; // RULE11
  assign sel_inbound = index_q[pibw_pkg::IDX_INBOUND_BIT];

  // ==========================================================
  // strap capture once after reset release
  always_comb begin
    strap_taken_d = 1'b1;
    endpoint_mode_d = endpoint_mode_q;
    lane_width_one_d = lane_width_one_q;
    lane_width_two_d = lane_width_two_q;
    link_speed_one_d = link_speed_one_q;
    link_speed_two_d = link_speed_two_q;
    if (!strap_taken_q) begin
      endpoint_mode_d =
        (host_agent_select == pibw_pkg::HOST_AGENT_ENDPOINT); // RULE1
      lane_width_one_d = serdes_protocol_field_one; // RULE2
      lane_width_two_d = serdes_protocol_field_two; // RULE2
      link_speed_one_d = serdes_speed_divider_one; // RULE3
      link_speed_two_d = serdes_speed_divider_two; // RULE3
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_taken_q <= 1'b0;
      endpoint_mode_q <= 1'b0;
      lane_width_one_q <= 16'h0;
      lane_width_two_q <= 16'h0;
      link_speed_one_q <= 2'h0;
      link_speed_two_q <= 2'h0;
    end else begin
      strap_taken_q <= strap_taken_d;
      endpoint_mode_q <= endpoint_mode_d;
      lane_width_one_q <= lane_width_one_d;
      lane_width_two_q <= lane_width_two_d;
      link_speed_one_q <= link_speed_one_d;
      link_speed_two_q <= link_speed_two_d;
    end
  end

  // ==========================================================
  // register writes and reads
  always_comb begin
    bar_base_d = bar_base_q;
    bar_mask_d = bar_mask_q;
    rc2_d = rc2_q;
    tgt_lo_d = tgt_lo_q;
    tgt_hi_d = tgt_hi_q;
    index_d = index_q;
    scratch_one_d = scratch_one_q;
    jump_d = jump_q;
    mailbox_d = mailbox_q;
    rdata_d = 32'h0;
    err_d = 1'b0;
    if (reg_valid) begin
      if (is_addr(reg_addr, pibw_pkg::OFF_BAR_ZERO_BASE)) begin
        rdata_d = bar_base_q[0]; // RULE10
        if (reg_write) bar_base_d[0] = reg_wdata;
      end else if (is_addr(reg_addr, pibw_pkg::OFF_BAR_ONE_BASE)) begin
        rdata_d = bar_base_q[1]; // RULE10
        if (reg_write) bar_base_d[1] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_BAR_ZERO_SIZE_MASK)) begin
        rdata_d = bar_mask_q[0]; // RULE9
        if (reg_write) bar_mask_d[0] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_BAR_ONE_SIZE_MASK)) begin
        rdata_d = bar_mask_q[1]; // RULE9
        if (reg_write) bar_mask_d[1] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_WINDOW_INDEX_SELECT)) begin
        rdata_d = index_q; // RULE11
        if (reg_write) index_d = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_WINDOW_REGION_CONTROL_TWO)) begin
        rdata_d = sel_inbound ? rc2_q[sel_win] : 32'h0; // RULE12
        if (reg_write && sel_inbound) rc2_d[sel_win] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_WINDOW_TARGET_LOWER)) begin
        rdata_d = sel_inbound ? tgt_lo_q[sel_win] : 32'h0; // RULE13
        if (reg_write && sel_inbound) tgt_lo_d[sel_win] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_WINDOW_TARGET_UPPER)) begin
        rdata_d = sel_inbound ? tgt_hi_q[sel_win] : 32'h0; // RULE13
        if (reg_write && sel_inbound) tgt_hi_d[sel_win] = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_BOOT_SCRATCH_ONE)) begin
        rdata_d = scratch_one_q; // RULE5
        if (reg_write) scratch_one_d = reg_wdata;
      end else if (is_addr(reg_addr,
                           pibw_pkg::OFF_BOOT_JUMP_SCRATCH)) begin
        rdata_d = jump_q; // RULE4
        if (reg_write) jump_d = reg_wdata;
      end else if (is_addr(reg_addr, pibw_pkg::MAILBOX_ADDR)) begin
        rdata_d = mailbox_q; // RULE14
        if (reg_write) mailbox_d = reg_wdata;
      end else begin
        err_d = 1'b1; // unmapped: read zero, write dropped
      end
    end
    // firmware clears mailbox on entry; a same-cycle host write wins
    if (boot_q == PIBW_BOOT_CLEAR &&
        !(reg_valid && reg_write &&
          is_addr(reg_addr, pibw_pkg::MAILBOX_ADDR))) begin
      mailbox_d = pibw_pkg::RESET_ZERO; // RULE14
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        bar_base_q[i] <= pibw_pkg::RESET_ZERO;
        rc2_q[i] <= pibw_pkg::RESET_ZERO;
        tgt_lo_q[i] <= pibw_pkg::RESET_ZERO;
        tgt_hi_q[i] <= pibw_pkg::RESET_ZERO;
      end
      bar_mask_q[0] <= pibw_pkg::BAR_ZERO_MASK_RESET;
      bar_mask_q[1] <= pibw_pkg::BAR_ONE_MASK_RESET;
      index_q <= pibw_pkg::RESET_ZERO;
      scratch_one_q <= pibw_pkg::RESET_ZERO; // RULE5
      jump_q <= pibw_pkg::RESET_JUMP_ADDR; // RULE4
      mailbox_q <= pibw_pkg::RESET_ZERO;
      reg_rdata_q <= 32'h0;
      reg_error_q <= 1'b0;
    end else begin
      bar_base_q <= bar_base_d;
      bar_mask_q <= bar_mask_d;
      rc2_q <= rc2_d;
      tgt_lo_q <= tgt_lo_d;
      tgt_hi_q <= tgt_hi_d;
      index_q <= index_d;
      scratch_one_q <= scratch_one_d;
      jump_q <= jump_d;
      mailbox_q <= mailbox_d;
      reg_rdata_q <= rdata_d;
      reg_error_q <= err_d;
    end
  end

  // ==========================================================
  // boot release: clear mailbox, wait non-zero, fetch from dram
  always_comb begin
    boot_d = boot_q;
    fetch_d = boot_fetch_addr_q;
    unique case (boot_q)
      PIBW_BOOT_CLEAR: begin
        fetch_d = jump_q; // RULE4
        boot_d = PIBW_BOOT_WAIT;
      end
      PIBW_BOOT_WAIT: begin
        if (mailbox_q != pibw_pkg::RESET_ZERO) begin
          boot_d = PIBW_BOOT_RUN; // RULE14
          fetch_d = pibw_pkg::DRAM_BOOT_ADDR;
        end
      end
      PIBW_BOOT_RUN: begin
        fetch_d = pibw_pkg::DRAM_BOOT_ADDR;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      boot_q <= PIBW_BOOT_CLEAR;
      boot_fetch_addr_q <= pibw_pkg::RESET_ZERO;
      boot_released_q <= 1'b0;
    end else begin
      boot_q <= boot_d;
      boot_fetch_addr_q <= fetch_d;
      boot_released_q <= (boot_d == PIBW_BOOT_RUN);
    end
  end

  // ==========================================================
  // inbound windows, live only in endpoint mode after training
  generate
    for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
      pibw_win_if wif ();
      assign wif.enable = rc2_q[w][pibw_pkg::RC2_ENABLE_BIT] &&
        endpoint_mode_q && link_up; // RULE6
      assign wif.bar_match = rc2_q[w][pibw_pkg::RC2_BAR_MATCH_BIT];
      assign wif.bar_sel = rc2_q[w][pibw_pkg::RC2_BAR_LSB]; // RULE12
      assign wif.bar_base = bar_base_q[w];
      assign wif.bar_mask = bar_mask_q[w];
      assign wif.target = {tgt_hi_q[w], tgt_lo_q[w]}; // RULE13
      pibw_xlat u_xlat (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .win(wif),
        .req_valid(req_valid),
        .req_bar(req_bar),
        .req_addr(req_addr),
        .hit_q(hit[w]),
        .local_addr_q(laddr[w])
      );
    end
  endgenerate

  // ==========================================================
  // merge window results; window 0 wins if both match
  always_comb begin
    dest_valid_d = |hit;
    resp_hit_q = dest_valid_q;
    resp_dest_q = pibw_pkg::PIBW_DEST_NONE;
    resp_local_addr_q = 64'h0;
    if (hit[0]) begin
      resp_dest_q = pibw_pkg::PIBW_DEST_REGS_RAM; // RULE7
      resp_local_addr_q = laddr[0];
    end else if (hit[1]) begin
      resp_dest_q = pibw_pkg::PIBW_DEST_DRAM; // RULE8
      resp_local_addr_q = laddr[1];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dest_valid_q <= 1'b0;
    end else begin
      dest_valid_q <= dest_valid_d;
    end
  end
endmodule

// file: pibw_assertions.sv
/*
  checker for the inbound boot-window top, on its ports only.
  assumes straps stay steady while nrst is high.
*/
`timescale 1ns/1ps
module pibw_assertions (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // straps and link
  input wire logic [2:0] host_agent_select,
  input wire logic [15:0] serdes_protocol_field_one,
  input wire logic [15:0] serdes_protocol_field_two,
  input wire logic link_up,
  // register port
  input wire logic reg_valid,
  input wire logic reg_write,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata_q,
  input wire logic reg_error_q,
  // inbound and boot state
  input wire logic req_valid,
  input wire logic resp_hit_q,
  input wire logic [1:0] resp_dest_q,
  input wire logic endpoint_mode_q,
  input wire logic [15:0] lane_width_one_q,
  input wire logic [15:0] lane_width_two_q,
  input wire logic boot_released_q,
  input wire logic [31:0] boot_fetch_addr_q
);
  // ==========================================================
  // clocking and sequences
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_mask_wr;
    reg_valid && reg_write && reg_addr == 32'h0000_1010;
  endsequence
  sequence s_mask_rd;
    reg_valid && !reg_write && reg_addr == 32'h0000_1010;
  endsequence
  sequence s_mbox_go;
    reg_valid && reg_write && reg_wdata != 32'h0000_0000 &&
      reg_addr == pibw_pkg::MAILBOX_ADDR;
  endsequence
  // ==========================================================
  // straps and registers
  a_mode_strap: assert property (endpoint_mode_q |->
    host_agent_select == pibw_pkg::HOST_AGENT_ENDPOINT)
    else $error("endpoint mode without endpoint strap");
  a_lane_copy: assert property (endpoint_mode_q |->
    lane_width_one_q == serdes_protocol_field_one &&
    lane_width_two_q == serdes_protocol_field_two)
    else $error("lane width differs from strap");
  a_bar_mapped: assert property (reg_valid &&
    reg_addr inside {32'h0000_0010, 32'h0000_0014} |=> !reg_error_q)
    else $error("bar access flagged as unmapped");
  a_mask_store: assert property (s_mask_wr ##2 s_mask_rd |=>
    reg_rdata_q == $past(reg_wdata, 3))
    else $error("size mask did not keep written value");
  // ==========================================================
  // inbound windows
  a_nolink_miss: assert property (req_valid && !link_up |=>
    resp_dest_q == pibw_pkg::PIBW_DEST_NONE)
    else $error("request routed while link down");
  a_hit_follows: assert property (
    resp_dest_q != pibw_pkg::PIBW_DEST_NONE |=> resp_hit_q)
    else $error("hit flag missing after routed request");
  // ==========================================================
  // boot release
  a_mbox_release: assert property (s_mbox_go |->
    ##[2:3] boot_released_q)
    else $error("boot not released after mailbox write");
  a_release_dram: assert property (boot_released_q |=>
    boot_fetch_addr_q == pibw_pkg::DRAM_BOOT_ADDR)
    else $error("released boot not fetching from dram");
  a_release_holds: assert property (
    boot_released_q |=> boot_released_q)
    else $error("boot release dropped");
endmodule
bind pibw_top pibw_assertions chk_u (.*);

// file: pibw_rc_model.sv
/*
  root complex model: issues inbound memory requests.
  assumes the bench calls send from its main process.
*/
`timescale 1ns/1ps
module pibw_rc_model (
  // clock
  input wire logic sys_clk,
  // inbound request lines
  output logic req_valid,
  output logic req_bar,
  output logic [31:0] req_addr
);
  // lines idle at time zero
  initial begin
    req_valid = 1'b0;
    req_bar = 1'b0;
    req_addr = 32'h0000_0000;
  end
  // one request after gap idle cycles, then the lines are let go
  task automatic send(input logic bar, input logic [31:0] a,
      input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_bar <= bar;
    req_addr <= a;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    req_bar <= ~bar; // released lines show the inverse
    req_addr <= ~a;
  endtask
endmodule

// file: pibw_top_tb_top.sv
/*
  testbench for the inbound boot-window top.
  assumes the root complex model drives the inbound lines.
*/
`timescale 1ns/1ps
module pibw_top_tb_top;
  // ==========================================================
  // signals
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] host_agent_select = 3'h1;
  logic [15:0] serdes_protocol_field_one = 16'h1133;
  logic [15:0] serdes_protocol_field_two = 16'h5506;
  logic [1:0] serdes_speed_divider_one = 2'h0;
  logic [1:0] serdes_speed_divider_two = 2'h0;
  logic link_up = 1'b0;
  logic reg_valid = 1'b0;
  logic reg_write = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_ready, reg_error_q, req_valid, req_bar, resp_hit_q;
  logic endpoint_mode_q, boot_released_q;
  logic [31:0] reg_rdata_q, req_addr, boot_fetch_addr_q;
  logic [1:0] resp_dest_q, link_speed_one_q, link_speed_two_q;
  logic [15:0] lane_width_one_q, lane_width_two_q;
  logic [63:0] resp_local_addr_q;
  int miscompares = 0;
  int checked = 0;
  // ==========================================================
  // design, far-side model and clock
  pibw_top dut_u (.*);
  pibw_rc_model rc_u (.*);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // shared tasks
  task automatic check(input string w, input logic [63:0] seen,
      input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one register access, answer sampled after the taking edge
  task automatic acc(input logic wr, input logic [31:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    reg_valid <= 1'b1;
    reg_write <= wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_valid <= 1'b0;
    reg_addr <= ~a; // released lines show the inverse
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rdchk(input string w, input logic [31:0] a,
      input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    check(w, 64'(reg_rdata_q), 64'(e));
  endtask
  task automatic do_reset(input logic [2:0] strap);
    @(posedge sys_clk);
    nrst <= 1'b0;
    host_agent_select <= strap;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
  endtask
  // inbound request, route at +1 and hit flag at +2
  task automatic inbound(input logic bar, input logic [31:0] a,
      input int gap, input logic [1:0] dest, input logic [63:0] la);
    rc_u.send(bar, a, gap);
    #1;
    check("dest", 64'(resp_dest_q), 64'(dest));
    if (dest != 2'h0) begin
      check("local address", resp_local_addr_q, la);
    end
    @(posedge sys_clk);
    #1;
    check("hit", 64'(resp_hit_q), 64'(dest != 2'h0));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] ra [7] = '{32'h10, 32'h14, 32'h900, 32'h1010,
      32'h1014, 32'h157_0600, 32'h157_0604};
    logic [31:0] re [7] = '{32'h0, 32'h0, 32'h0, 32'h1fff_ffff,
      32'h1fff_ffff, 32'h0, 32'h1000_0000};
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 7; i++) begin
      rdchk("reset value", ra[i], re[i]);
    end
    check("mode", 64'(endpoint_mode_q), 64'h1);
    check("lane one", 64'(lane_width_one_q), 64'h1133);
    check("lane two", 64'(lane_width_two_q), 64'h5506);
    check("speed one", 64'(link_speed_one_q), 64'h0);
    check("speed two", 64'(link_speed_two_q), 64'h0);
    check("fetch", 64'(boot_fetch_addr_q), 64'h1000_0000);
    check("ready", 64'(reg_ready), 64'h1);
  endtask
  task automatic t_regs();
    acc(1'b0, 32'h0000_0004, 32'h0);
    check("unmapped error", 64'(reg_error_q), 64'h1);
    check("unmapped data", 64'(reg_rdata_q), 64'h0);
    acc(1'b1, 32'h908, 32'hc000_0000);
    rdchk("region gated", 32'h908, 32'h0);
    acc(1'b1, 32'h1010, 32'h0fff_0000);
    rdchk("mask store", 32'h1010, 32'h0fff_0000);
    acc(1'b1, 32'h157_0600, 32'h0);
    acc(1'b1, 32'h157_0604, 32'h1000_0000);
    rdchk("jump", 32'h157_0604, 32'h1000_0000);
  endtask
  task automatic t_windows();
    logic [31:0] wa [12] = '{32'h1010, 32'h10, 32'h900, 32'h908,
      32'h918, 32'h91c, 32'h1014, 32'h14, 32'h900, 32'h908, 32'h918,
      32'h91c};
    logic [31:0] wd [12] = '{32'h1fff_ffff, 32'h8000_0000,
      32'h8000_0000, 32'hc000_0000, 32'h8000_0000, 32'h0,
      32'h01ff_ffff, 32'h0, 32'h8000_0001, 32'hc000_0100, 32'h0, 32'h0};
    for (int i = 0; i < 12; i++) begin
      acc(1'b1, wa[i], wd[i]);
    end
    rdchk("ctrl one", 32'h908, 32'hc000_0100);
    rdchk("bar zero", 32'h10, 32'h8000_0000);
    acc(1'b1, 32'h900, 32'h8000_0000);
    rdchk("ctrl zero", 32'h908, 32'hc000_0000);
    rdchk("target zero", 32'h918, 32'h8000_0000);
    inbound(1'b0, 32'h4, 0, 2'h0, 64'h0);
    @(posedge sys_clk);
    link_up <= 1'b1;
    inbound(1'b0, 32'h4, 0, 2'h1, 64'h8000_0004);
    inbound(1'b1, 32'h2000_0010, 3, 2'h2, 64'h10);
    inbound(1'b0, 32'he000_0008, 0, 2'h1, 64'h8000_0008);
  endtask
  task automatic t_mailbox();
    int n;
    n = 0;
    acc(1'b1, 32'h1001_0000, 32'h0);
    rdchk("mailbox", 32'h1001_0000, 32'h0);
    check("held", 64'(boot_released_q), 64'h0);
    acc(1'b1, 32'h1001_0000, 32'h0000_0001);
    while (boot_released_q !== 1'b1) begin
      if (n == 4) begin
        miscompares++;
        conclude();
      end
      n++;
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    check("fetch", 64'(boot_fetch_addr_q), 64'h8200_0000);
  endtask
  task automatic t_rereset();
    do_reset(3'h0);
    repeat (2) @(posedge sys_clk);
    #1;
    check("host mode", 64'(endpoint_mode_q), 64'h0);
    check("boot held", 64'(boot_released_q), 64'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    do_reset(3'h1);
    t_reset();
    t_regs();
    t_windows();
    t_mailbox();
    t_rereset();
    conclude();
  end
endmodule
